// File: design/lpac_top.sv
`timescale 1ns/1ps
`default_nettype none
module lpac_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_wide,
  input  wire logic [15:0] io_addr,
  input  wire logic [15:0] io_wdata,
  output logic      [15:0] io_rdata_q,
  output logic             io_rvalid_q,
  input  wire logic        fb_wr,
  input  wire logic        fb_rd,
  input  wire logic        fb_paged,
  input  wire logic [17:0] fb_addr,
  input  wire logic [7:0]  fb_wdata,
  output logic             fb_busy_q,
  output logic             fb_done_q,
  output logic      [7:0]  fb_rdata_q,
  output logic             mem_wr_q,
  output logic             mem_rd_q,
  output logic      [15:0] mem_addr_q,
  output logic      [3:0]  mem_plane_en_q,
  output logic      [31:0] mem_wdata_q,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  output logic      [2:0]  font_pri_map_q,
  output logic      [2:0]  font_sec_map_q,
  output logic      [15:0] font_pri_base_q,
  output logic      [15:0] font_sec_base_q,
  output logic             attr_font_sel_q
);

  typedef enum logic [0:0] {LPAC_IDLE, LPAC_RD_WAIT} lpac_state_e;

  logic [2:0]  seq_index_q;
  logic [4:0]  gr_index_q;
  logic [3:0]  plane_write_mask_q;
  logic [5:0]  font_map_select_q;
  logic [2:0]  memory_mode_q;
  logic [7:0]  horizontal_counter_reset_q;
  logic [3:0]  plane_fill_value_q;
  logic [3:0]  plane_fill_enable_q;
  logic [3:0]  color_compare_q;
  logic [4:0]  rotate_and_function_q;
  logic [1:0]  read_plane_select_q;
  logic [6:0]  graphics_mode_q;
  logic [3:0]  compare_dont_care_q;
  logic [7:0]  bit_write_mask_q;
  logic [31:0] latch_q;
  logic        rd_cmp_q;
  logic [1:0]  rd_plane_q;
  lpac_state_e state_q;

  // Rotate right, shared by write modes 0 and 3
  function automatic logic [7:0] ror8(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] t;
    t = {d, d} >> n;
    return t[7:0];
  endfunction

  // Latch logic unit
  function automatic logic [7:0] alu8(input logic [1:0] fn, input logic [7:0] d, input logic [7:0] l);
    logic [7:0] r;
    r = d;
    case (fn)
      lpac_pkg::FN_PASS: r = d;
      lpac_pkg::FN_AND:  r = d & l;
      lpac_pkg::FN_OR:   r = d | l;
      lpac_pkg::FN_XOR:  r = d ^ l;
      default:           r = d;
    endcase
    return r;
  endfunction

  // Sequencer data readback; unmapped indices read zero
  function automatic logic [7:0] seq_rd(input logic [2:0] idx, input logic [3:0] pwm, input logic [5:0] fms,
                                         input logic [2:0] mm, input logic [7:0] hcr);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      lpac_pkg::SEQ_PLANE_MASK: r = {4'h0, pwm};
      lpac_pkg::SEQ_FONT_MAP:   r = {2'h0, fms} & lpac_pkg::MASK_FONT_MAP;
      lpac_pkg::SEQ_MEM_MODE:   r = {4'h0, mm, 1'b0} & lpac_pkg::MASK_MEM_MODE;
      lpac_pkg::SEQ_HCNT_RESET: r = hcr;
      default:                  r = 8'h00;
    endcase
    return r;
  endfunction

  // Graphics data readback over indices 00 to 18
  function automatic logic [7:0] gr_rd(input logic [4:0] idx, input logic [3:0] fv, input logic [3:0] fe,
                                        input logic [3:0] cc, input logic [4:0] rf, input logic [1:0] rp,
                                        input logic [6:0] gm, input logic [3:0] dc, input logic [7:0] bm);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      lpac_pkg::GR_FILL_VALUE:  r = {4'h0, fv};
      lpac_pkg::GR_FILL_ENABLE: r = {4'h0, fe};
      lpac_pkg::GR_COLOR_CMP:   r = {4'h0, cc};
      lpac_pkg::GR_ROT_FUNC:    r = {3'h0, rf};
      lpac_pkg::GR_READ_PLANE:  r = {6'h00, rp};
      lpac_pkg::GR_MODE:        r = {1'b0, gm} & lpac_pkg::MASK_GR_MODE;
      lpac_pkg::GR_DONT_CARE:   r = {4'h0, dc};
      lpac_pkg::GR_BIT_MASK:    r = bm;
      default:                  r = 8'h00;
    endcase
    return r;
  endfunction

  // Port decode; a wide access at an index port puts data in the upper byte
  logic       seq_idx_wr;
  logic       gr_idx_wr;
  logic       seq_dat_wr;
  logic       gr_dat_wr;
  logic [7:0] seq_dat;
  logic [7:0] gr_dat;
  logic [2:0] seq_idx_eff;
  logic [4:0] gr_idx_eff;

  always_comb begin
    seq_idx_wr  = io_wr && (io_addr == lpac_pkg::IO_SEQ_INDEX);
    gr_idx_wr   = io_wr && (io_addr == lpac_pkg::IO_GR_INDEX);
    seq_dat_wr  = io_wr && ((io_addr == lpac_pkg::IO_SEQ_DATA) || (seq_idx_wr && io_wide));
    gr_dat_wr   = io_wr && ((io_addr == lpac_pkg::IO_GR_DATA) || (gr_idx_wr && io_wide));
    seq_dat     = (io_addr == lpac_pkg::IO_SEQ_DATA) ? io_wdata[7:0] : io_wdata[15:8];
    gr_dat      = (io_addr == lpac_pkg::IO_GR_DATA) ? io_wdata[7:0] : io_wdata[15:8];
    // A word write addresses the data with the index it carries
    seq_idx_eff = seq_idx_wr ? io_wdata[2:0] : seq_index_q;
    gr_idx_eff  = gr_idx_wr ? io_wdata[4:0] : gr_index_q;
  end

  // Index registers stay put until the next index write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_index_q <= 3'h0;
      gr_index_q  <= 5'h00;
    end else begin
      if (seq_idx_wr) seq_index_q <= io_wdata[2:0];
      if (gr_idx_wr)  gr_index_q  <= io_wdata[4:0];
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      plane_write_mask_q         <= lpac_pkg::RST_REG[3:0];
      font_map_select_q          <= lpac_pkg::RST_REG[5:0];
      memory_mode_q              <= lpac_pkg::RST_REG[3:1];
      horizontal_counter_reset_q <= lpac_pkg::RST_REG;
    end else if (seq_dat_wr) begin
      case (seq_idx_eff)
        lpac_pkg::SEQ_PLANE_MASK: plane_write_mask_q <= seq_dat[3:0];
        lpac_pkg::SEQ_FONT_MAP:   font_map_select_q  <= seq_dat[5:0];
        lpac_pkg::SEQ_MEM_MODE:   memory_mode_q      <= seq_dat[3:1];
        // Plain storage; no counter is held or released here
        lpac_pkg::SEQ_HCNT_RESET: horizontal_counter_reset_q <= seq_dat;
        default: ;
      endcase
    end
  end

  // Graphics controller registers; the unused indices ignore writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      plane_fill_value_q    <= lpac_pkg::RST_REG[3:0];
      plane_fill_enable_q   <= lpac_pkg::RST_REG[3:0];
      color_compare_q       <= lpac_pkg::RST_REG[3:0];
      rotate_and_function_q <= lpac_pkg::RST_REG[4:0];
      read_plane_select_q   <= lpac_pkg::RST_REG[1:0];
      graphics_mode_q       <= lpac_pkg::RST_REG[6:0];
      compare_dont_care_q   <= lpac_pkg::RST_REG[3:0];
      bit_write_mask_q      <= lpac_pkg::RST_BIT_MASK;
    end else if (gr_dat_wr) begin
      case (gr_idx_eff)
        lpac_pkg::GR_FILL_VALUE:  plane_fill_value_q    <= gr_dat[3:0];
        lpac_pkg::GR_FILL_ENABLE: plane_fill_enable_q   <= gr_dat[3:0];
        lpac_pkg::GR_COLOR_CMP:   color_compare_q       <= gr_dat[3:0];
        lpac_pkg::GR_ROT_FUNC:    rotate_and_function_q <= gr_dat[4:0];
        lpac_pkg::GR_READ_PLANE:  read_plane_select_q   <= gr_dat[1:0];
        lpac_pkg::GR_MODE:        graphics_mode_q       <= gr_dat[6:0];
        lpac_pkg::GR_DONT_CARE:   compare_dont_care_q   <= gr_dat[3:0];
        lpac_pkg::GR_BIT_MASK:    bit_write_mask_q      <= gr_dat;
        default: ;
      endcase
    end
  end

  // Register readback, answered one cycle after the strobe
  logic [7:0] seq_val;
  logic [7:0] gr_val;
  logic [7:0] rd_lo;
  logic [7:0] rd_hi;

  always_comb begin
    seq_val = seq_rd(seq_index_q, plane_write_mask_q, font_map_select_q, memory_mode_q,
                     horizontal_counter_reset_q);
    gr_val  = (gr_index_q <= lpac_pkg::GR_INDEX_LAST) ?
              gr_rd(gr_index_q, plane_fill_value_q, plane_fill_enable_q, color_compare_q,
                    rotate_and_function_q, read_plane_select_q, graphics_mode_q,
                    compare_dont_care_q, bit_write_mask_q) : 8'h00;
    rd_lo   = 8'h00;
    rd_hi   = 8'h00;
    case (io_addr)
      lpac_pkg::IO_SEQ_INDEX: begin
        rd_lo = {5'h00, seq_index_q} & lpac_pkg::MASK_SEQ_INDEX;
        rd_hi = io_wide ? seq_val : 8'h00;
      end
      lpac_pkg::IO_SEQ_DATA: rd_lo = seq_val;
      lpac_pkg::IO_GR_INDEX: begin
        rd_lo = {3'h0, gr_index_q} & lpac_pkg::MASK_GR_INDEX;
        rd_hi = io_wide ? gr_val : 8'h00;
      end
      lpac_pkg::IO_GR_DATA: rd_lo = gr_val;
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_rdata_q  <= 16'h0000;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_rd;
      if (io_rd) io_rdata_q <= {rd_hi, rd_lo};
    end
  end

  // Font map decode, registered for the display side
  logic [2:0] pri_num;
  logic [2:0] sec_num;
  logic [2:0] pri_slot;
  logic [2:0] sec_slot;
  logic       ext_mem;

  always_comb begin
    ext_mem = memory_mode_q[lpac_pkg::MM_EXT_MEM - 1];
    if (ext_mem) begin
      pri_num  = {font_map_select_q[lpac_pkg::FM_PRI_HI], font_map_select_q[lpac_pkg::FM_PRI_LO +: 2]};
      sec_num  = {font_map_select_q[lpac_pkg::FM_SEC_HI], font_map_select_q[lpac_pkg::FM_SEC_LO +: 2]};
      pri_slot = {font_map_select_q[lpac_pkg::FM_PRI_LO +: 2], font_map_select_q[lpac_pkg::FM_PRI_HI]};
      sec_slot = {font_map_select_q[lpac_pkg::FM_SEC_LO +: 2], font_map_select_q[lpac_pkg::FM_SEC_HI]};
    end else begin
      // Only maps 0 and 4 reachable without extended memory
      pri_num  = {font_map_select_q[lpac_pkg::FM_PRI_HI], 2'h0};
      sec_num  = {font_map_select_q[lpac_pkg::FM_SEC_HI], 2'h0};
      pri_slot = {2'h0, font_map_select_q[lpac_pkg::FM_PRI_HI]};
      sec_slot = {2'h0, font_map_select_q[lpac_pkg::FM_SEC_HI]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      font_pri_map_q  <= 3'h0;
      font_sec_map_q  <= 3'h0;
      font_pri_base_q <= 16'h0000;
      font_sec_base_q <= 16'h0000;
      attr_font_sel_q <= 1'b0;
    end else begin
      font_pri_map_q  <= pri_num;
      font_sec_map_q  <= sec_num;
      font_pri_base_q <= {pri_slot, 13'h0000};
      font_sec_base_q <= {sec_slot, 13'h0000};
      // Equal maps leave attribute bit 3 as intensity
      attr_font_sel_q <= ext_mem && (pri_num != sec_num);
    end
  end

  // Frame-buffer address steering
  logic        quad;
  logic        paired;
  logic        in_range;
  logic [15:0] pl_addr;
  logic [3:0]  pl_en;
  logic [1:0]  rd_plane;

  always_comb begin
    quad     = memory_mode_q[lpac_pkg::MM_QUAD - 1];
    paired   = !quad && !memory_mode_q[lpac_pkg::MM_PAIR_OFF - 1] && !fb_paged;
    in_range = ext_mem || (fb_addr[17:16] == 2'h0);
    if (quad) begin
      pl_addr  = fb_addr[17:2];
      pl_en    = (4'h1 << fb_addr[1:0]) & plane_write_mask_q;
      rd_plane = fb_addr[1:0];
    end else if (paired) begin
      pl_addr  = fb_addr[16:1];
      pl_en    = (fb_addr[0] ? 4'ha : 4'h5) & plane_write_mask_q;
      rd_plane = {read_plane_select_q[1], fb_addr[0]};
    end else begin
      // Sequential addressing, planes picked by the write mask
      pl_addr  = fb_addr[15:0];
      pl_en    = plane_write_mask_q;
      rd_plane = read_plane_select_q;
    end
  end

  // Write data path per plane
  logic [31:0] wr_data;
  logic [7:0]  rot;
  logic [7:0]  src;
  logic [7:0]  msk;
  logic [7:0]  lat;
  logic [1:0]  wmode;

  always_comb begin
    wmode   = graphics_mode_q[lpac_pkg::GM_WMODE_LO +: 2];
    rot     = ror8(fb_wdata, rotate_and_function_q[lpac_pkg::RF_ROT_LO +: 3]);
    wr_data = 32'h0000_0000;
    src     = 8'h00;
    msk     = 8'h00;
    lat     = 8'h00;
    for (int p = 0; p < 4; p++) begin
      lat = latch_q[8*p +: 8];
      msk = bit_write_mask_q;
      case (wmode)
        // Rotate, substitute, latch function, then bit mask
        lpac_pkg::WM_0: src = plane_fill_enable_q[p] ? {8{plane_fill_value_q[p]}} : rot;
        lpac_pkg::WM_1: begin
          src = lat;
          msk = 8'hff;
        end
        lpac_pkg::WM_2: src = {8{fb_wdata[p]}};
        lpac_pkg::WM_3: begin
          src = {8{plane_fill_value_q[p]}};
          msk = rot & bit_write_mask_q;
        end
        default: src = rot;
      endcase
      if (wmode != lpac_pkg::WM_1) begin
        src = alu8(rotate_and_function_q[lpac_pkg::RF_FUNC_LO +: 2], src, lat);
      end
      wr_data[8*p +: 8] = (src & msk) | (lat & ~msk);
    end
  end

  // Read mode 1 colour compare across cared planes
  logic [7:0] cmp_res;
  logic [7:0] rd_byte;

  always_comb begin
    cmp_res = 8'hff;
    for (int p = 0; p < 4; p++) begin
      if (compare_dont_care_q[p]) begin
        cmp_res = cmp_res & ~(mem_rdata[8*p +: 8] ^ {8{color_compare_q[p]}});
      end
    end
    rd_byte = rd_cmp_q ? cmp_res : mem_rdata[8*rd_plane_q +: 8];
  end

  // Access sequencer; writes and out-of-range reads finish at once, other reads wait for memory
  logic accept;

  always_comb begin
    accept = (state_q == LPAC_IDLE) && (fb_wr || fb_rd);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q        <= LPAC_IDLE;
      fb_busy_q      <= 1'b0;
      fb_done_q      <= 1'b0;
      fb_rdata_q     <= 8'h00;
      mem_wr_q       <= 1'b0;
      mem_rd_q       <= 1'b0;
      mem_addr_q     <= 16'h0000;
      mem_plane_en_q <= 4'h0;
      mem_wdata_q    <= 32'h0000_0000;
      rd_cmp_q       <= 1'b0;
      rd_plane_q     <= 2'h0;
    end else begin
      mem_wr_q  <= 1'b0;
      mem_rd_q  <= 1'b0;
      fb_done_q <= 1'b0;
      case (state_q)
        LPAC_IDLE: begin
          if (accept && fb_wr) begin
            // Out-of-range writes are dropped but still acknowledged
            mem_wr_q       <= in_range;
            mem_addr_q     <= pl_addr;
            mem_plane_en_q <= pl_en;
            mem_wdata_q    <= wr_data;
            fb_done_q      <= 1'b1;
          end else if (accept && fb_rd && !in_range) begin
            fb_rdata_q <= 8'h00;
            fb_done_q  <= 1'b1;
          end else if (accept) begin
            mem_rd_q   <= 1'b1;
            mem_addr_q <= pl_addr;
            rd_cmp_q   <= graphics_mode_q[lpac_pkg::GM_RMODE];
            rd_plane_q <= rd_plane;
            fb_busy_q  <= 1'b1;
            state_q    <= LPAC_RD_WAIT;
          end
        end
        LPAC_RD_WAIT: begin
          if (mem_rvalid) begin
            fb_rdata_q <= rd_byte;
            fb_done_q  <= 1'b1;
            fb_busy_q  <= 1'b0;
            state_q    <= LPAC_IDLE;
          end
        end
        default: state_q <= LPAC_IDLE;
      endcase
    end
  end

  // Read latches copy every plane read untouched
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch_q <= 32'h0000_0000;
    end else if ((state_q == LPAC_RD_WAIT) && mem_rvalid) begin
      latch_q <= mem_rdata;
    end
  end

endmodule
`default_nettype wire

// File: design/lpac_pkg.sv
// How it works
// - Attribute bit 3 picks the font map when extended memory is on and the two map numbers differ, else intensity.
// - Font map choice works only with extended memory on; otherwise maps 0 and 4 only.
// - Secondary map number is bits 3:2 plus four times bit 5; slot is {3:2,5}.
// - Primary map uses bits 1:0 and bit 4 the same way; slots span 0 to 56K.
// - Quad-plane interleave makes CPU address bits 1:0 pick the plane, reads and writes.
// - Even/odd pairing acts only with interleave off and on non-paged aperture accesses.
// - Pairing bit 0 steers even to planes 0,2, odd to 1,3; 1 is sequential.
// - Extended memory off limits CPU to the first 64KB, on reaches all 256KB.
// - Horizontal counter reset write only stores the byte; no counter hold effect.
// - Host writes a 5-bit graphics index, then uses the data port; indices 00 to 18.
// - Write mode 0 fills planes with fill enable set with their fill value bit.
// - Fill enable matters only in write mode 0; disabled planes take the rotated CPU data.
// - Write mode 3 uses rotated data AND bit mask as mask, fill value as color.
// - Read mode 1 compares each plane byte with its compare bit, cared planes only.
// - Read mode 1 returns 8 bits, each 1 when all included planes match.
// - Function select 00 pass, 01 AND, 10 OR, 11 XOR with the read latch.
// - Rotate count rotates CPU write data right in write modes 0 and 3.
// - Reserved bits of font map select and memory mode read as zero.
// - Write mode field picks modes 0 to 3; mode 0 writes rotated data to planes with fill enable clear.
// - Each read latch holds an unaltered copy of the last byte read from its plane.
// - Read mode 0 in sequential addressing returns the byte of the plane named by read plane select.
// - Plane write mask gates writes per plane in both interleaved modes.
package lpac_pkg;
  // I/O port addresses
  localparam logic [15:0] IO_SEQ_INDEX = 16'h03c4;
  localparam logic [15:0] IO_SEQ_DATA  = 16'h03c5;
  localparam logic [15:0] IO_GR_INDEX  = 16'h03ce;
  localparam logic [15:0] IO_GR_DATA   = 16'h03cf;
  // Sequencer indices
  localparam logic [2:0] SEQ_PLANE_MASK = 3'h2;
  localparam logic [2:0] SEQ_FONT_MAP   = 3'h3;
  localparam logic [2:0] SEQ_MEM_MODE   = 3'h4;
  localparam logic [2:0] SEQ_HCNT_RESET = 3'h7;
  // Graphics indices
  localparam logic [4:0] GR_FILL_VALUE  = 5'h00;
  localparam logic [4:0] GR_FILL_ENABLE = 5'h01;
  localparam logic [4:0] GR_COLOR_CMP   = 5'h02;
  localparam logic [4:0] GR_ROT_FUNC    = 5'h03;
  localparam logic [4:0] GR_READ_PLANE  = 5'h04;
  localparam logic [4:0] GR_MODE        = 5'h05;
  localparam logic [4:0] GR_DONT_CARE   = 5'h07;
  localparam logic [4:0] GR_BIT_MASK    = 5'h08;
  localparam logic [4:0] GR_INDEX_LAST  = 5'h18;
  // Readable bits of each register
  localparam logic [7:0] MASK_SEQ_INDEX = 8'h07;
  localparam logic [7:0] MASK_GR_INDEX  = 8'h1f;
  localparam logic [7:0] MASK_NIBBLE    = 8'h0f;
  localparam logic [7:0] MASK_FONT_MAP  = 8'h3f;
  localparam logic [7:0] MASK_MEM_MODE  = 8'h0e;
  localparam logic [7:0] MASK_ROT_FUNC  = 8'h1f;
  localparam logic [7:0] MASK_READ_PL   = 8'h03;
  localparam logic [7:0] MASK_GR_MODE   = 8'h7b;
  // Memory mode fields
  localparam int MM_EXT_MEM  = 1;
  localparam int MM_PAIR_OFF = 2;
  localparam int MM_QUAD     = 3;
  // Font map fields
  localparam int FM_PRI_LO = 0;
  localparam int FM_SEC_LO = 2;
  localparam int FM_PRI_HI = 4;
  localparam int FM_SEC_HI = 5;
  localparam int FONT_SLOT_SHIFT = 13;
  // Rotate / function fields
  localparam int RF_ROT_LO  = 0;
  localparam int RF_FUNC_LO = 3;
  // Graphics mode fields
  localparam int GM_WMODE_LO = 0;
  localparam int GM_RMODE    = 3;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_BIT_MASK = 8'hff;
  // Latch logic functions
  localparam logic [1:0] FN_PASS = 2'h0;
  localparam logic [1:0] FN_AND  = 2'h1;
  localparam logic [1:0] FN_OR   = 2'h2;
  localparam logic [1:0] FN_XOR  = 2'h3;
  // Write modes
  localparam logic [1:0] WM_0 = 2'h0;
  localparam logic [1:0] WM_1 = 2'h1;
  localparam logic [1:0] WM_2 = 2'h2;
  localparam logic [1:0] WM_3 = 2'h3;
endpackage

// File: tb/lpac_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lpac_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        io_rd,
  input wire logic [15:0] io_addr,
  input wire logic        io_rvalid_q,
  input wire logic        fb_wr,
  input wire logic        fb_rd,
  input wire logic        fb_busy_q,
  input wire logic        fb_done_q,
  input wire logic        mem_wr_q,
  input wire logic        mem_rd_q,
  input wire logic        mem_rvalid,
  input wire logic [2:0]  font_pri_map_q,
  input wire logic [2:0]  font_sec_map_q,
  input wire logic [15:0] font_pri_base_q,
  input wire logic [15:0] font_sec_base_q,
  input wire logic        attr_font_sel_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Port reads answer one cycle later, never unasked
  chk_io_read_answer: assert property (io_rd &&
      (io_addr[15:1] == 15'h01e2 || io_addr[15:1] == 15'h01e7) |=> io_rvalid_q)
    else $error("register read not answered");
  chk_io_answer_cause: assert property (io_rvalid_q |-> $past(io_rd))
    else $error("unrequested read answer");
  // Frame-buffer handshake
  chk_fb_write_ack: assert property (fb_wr && !fb_busy_q |=> fb_done_q)
    else $error("write not acknowledged");
  chk_fb_read_issue: assert property (fb_rd && !fb_wr && !fb_busy_q |=>
      (mem_rd_q && fb_busy_q) || fb_done_q)
    else $error("read not issued");
  chk_fb_read_done: assert property (fb_busy_q && mem_rvalid |=> fb_done_q && !fb_busy_q)
    else $error("read answer not returned");
  chk_plane_write_ack: assert property (mem_wr_q |-> fb_done_q)
    else $error("plane write without ack");
  // Font outputs tied to map numbers; slot is low bits then high bit
  chk_font_sel_diff: assert property (attr_font_sel_q |-> font_pri_map_q != font_sec_map_q)
    else $error("font select with equal maps");
  chk_pri_font_base: assert property (font_pri_base_q == {font_pri_map_q[1:0], font_pri_map_q[2], 13'h0000})
    else $error("primary base wrong");
  chk_sec_font_base: assert property (font_sec_base_q == {font_sec_map_q[1:0], font_sec_map_q[2], 13'h0000})
    else $error("secondary base wrong");
endmodule
bind lpac_top lpac_properties chk (.*);
`default_nettype wire

// File: tb/lpac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpac_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [3:0]  mem_plane_en,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  delay,
  output logic             mem_rvalid = 1'b0,
  output logic      [31:0] mem_rdata = 32'h5a5a5a5a
);
  logic [31:0] store [logic [15:0]];
  logic [31:0] word;
  // Four planes; data bus churns outside answers so stale bytes never match
  always @(posedge clk_sys) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    // Lookup only on a real access; the address is unknown before reset lands
    word = ((mem_wr | mem_rd) === 1'b1 && store.exists(mem_addr)) ? store[mem_addr] : 32'h0;
    if (mem_wr) begin
      for (int p = 0; p < 4; p++)
        if (mem_plane_en[p]) word[8*p +: 8] = mem_wdata[8*p +: 8];
      store[mem_addr] = word;
    end
    if (mem_rd) begin
      repeat (delay) @(posedge clk_sys);
      mem_rvalid <= 1'b1;
      mem_rdata <= word;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, io_wide = 1'b0;
  logic        fb_wr = 1'b0, fb_rd = 1'b0, fb_paged = 1'b0;
  logic [15:0] io_addr = 16'h0, io_wdata = 16'h0, io_rdata_q, mem_addr_q, font_pri_base_q, font_sec_base_q;
  logic [17:0] fb_addr = 18'h0;
  logic [7:0]  fb_wdata = 8'h0, fb_rdata_q;
  logic        io_rvalid_q, fb_busy_q, fb_done_q, mem_wr_q, mem_rd_q, mem_rvalid, attr_font_sel_q;
  logic [3:0]  mem_plane_en_q, delay = 4'h3;
  logic [31:0] mem_wdata_q, mem_rdata, e;
  logic [31:0] w = 32'h300030ff;
  logic [2:0]  font_pri_map_q, font_sec_map_q;
  int          fail_count = 0, checked = 0, cycles = 0;
  lpac_top uut (.*);
  lpac_mem_model planes (.clk_sys(clk_sys), .mem_wr(mem_wr_q), .mem_rd(mem_rd_q), .mem_addr(mem_addr_q),
    .mem_plane_en(mem_plane_en_q), .mem_wdata(mem_wdata_q), .delay(delay),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  always #50 clk_sys = ~clk_sys;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register port cycles; host stays on I/O space for every index
  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= {8'h00, d};
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask
  task automatic io_r(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 d = io_rdata_q;
  endtask
  task automatic sw(input logic [7:0] i, input logic [7:0] d);
    io_w(16'h03c4, i);
    io_w(16'h03c5, d);
  endtask
  task automatic gw(input logic [7:0] i, input logic [7:0] d);
    io_w(16'h03ce, i);
    io_w(16'h03cf, d);
  endtask
  task automatic reg_chk(input logic [15:0] a, input logic [7:0] i, input logic [7:0] x);
    logic [15:0] d;
    io_w(a, i);
    io_r(a + 16'h1, d);
    chk(d, {8'h00, x});
  endtask
  // Frame-buffer cycles; results are looked at once the answer lands
  task automatic fbw(input logic [17:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    fb_wr <= 1'b1;
    fb_addr <= a;
    fb_wdata <= d;
    @(posedge clk_sys);
    fb_wr <= 1'b0;
    #1;
  endtask
  task automatic fbr(input logic [17:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    fb_rd <= 1'b1;
    fb_addr <= a;
    @(posedge clk_sys);
    fb_rd <= 1'b0;
    #1;
    for (int n = 0; n < 20 && fb_done_q !== 1'b1; n++) @(posedge clk_sys) #1;
    chk(fb_done_q, 1);
    chk(fb_rdata_q, x);
  endtask
  task automatic t_regs();
    logic [15:0] d;
    reg_chk(16'h03c4, 8'h04, 8'h00);
    sw(8'h04, 8'hff);
    reg_chk(16'h03c4, 8'h04, 8'h0e);
    sw(8'h03, 8'hff);
    reg_chk(16'h03c4, 8'h03, 8'h3f);
    sw(8'h07, 8'ha5);
    reg_chk(16'h03c4, 8'h07, 8'ha5);
    gw(8'h03, 8'h1f);
    reg_chk(16'h03ce, 8'h03, 8'h1f);
    // Second data read with no index write in between
    io_r(16'h03cf, d);
    chk(d, 16'h001f);
    // Word write at the index port: index in the low byte, data in the high
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_wide <= 1'b1;
    io_addr <= 16'h03ce;
    io_wdata <= 16'h0c07;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_wide <= 1'b0;
    reg_chk(16'h03ce, 8'h07, 8'h0c);
    reg_chk(16'h03be, 8'h03, 8'h00);
  endtask
  task automatic t_font();
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? 3'(i) : 3'(7 - i);
      sw(8'h04, 8'h02);
      sw(8'h03, {2'h0, s[2], 1'(i >> 2), s[1:0], 2'(i)});
      repeat (2) @(posedge clk_sys);
      #1 chk(font_pri_map_q, 32'(i));
      chk(font_sec_map_q, s);
      chk(font_pri_base_q, 32'({2'(i), 1'(i >> 2), 13'h0}));
      chk(font_sec_base_q, 32'({s[1:0], s[2], 13'h0}));
      chk(attr_font_sel_q, s != 3'(i));
    end
    sw(8'h04, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk({attr_font_sel_q, font_pri_map_q, font_sec_map_q}, 32'h20);
  endtask
  task automatic t_write();
    sw(8'h04, 8'h06);
    sw(8'h02, 8'h0f);
    gw(8'h03, 8'h03);
    gw(8'h01, 8'h05);
    gw(8'h00, 8'h01);
    fbw(18'h00010, 8'h81);
    chk({mem_wr_q, mem_plane_en_q, mem_addr_q}, 32'h1f0010);
    chk(mem_wdata_q, w);
    for (int p = 0; p < 4; p++) begin
      gw(8'h04, 8'(p));
      fbr(18'h00010, w[8*p +: 8]);
    end
    gw(8'h01, 8'h00);
    for (int f = 0; f < 4; f++) begin
      gw(8'h03, 8'(f << 3));
      fbw(18'h00010, 8'h0f);
      for (int p = 0; p < 4; p++)
        e[8*p +: 8] = f == 0 ? 8'h0f : f == 1 ? 8'h0f & w[8*p +: 8] : f == 2 ? 8'h0f | w[8*p +: 8] : 8'h0f ^ w[8*p +: 8];
      chk(mem_wdata_q, e);
    end
    gw(8'h03, 8'h00);
    gw(8'h05, 8'h03);
    gw(8'h08, 8'h3c);
    gw(8'h00, 8'h0a);
    fbw(18'h00010, 8'hf0);
    chk(mem_wdata_q, 32'h300030cf);
    gw(8'h05, 8'h02);
    fbw(18'h00010, 8'h05);
    chk(mem_wdata_q, 32'h003c00ff);
    gw(8'h05, 8'h01);
    fbw(18'h00010, 8'h00);
    chk(mem_wdata_q, w);
    delay <= 4'h0;
    gw(8'h05, 8'h08);
    gw(8'h02, 8'h05);
    gw(8'h07, 8'h03);
    fbr(18'h00010, 8'hcf);
    gw(8'h07, 8'h00);
    fbr(18'h00010, 8'hff);
  endtask
  task automatic t_steer();
    gw(8'h05, 8'h00);
    gw(8'h08, 8'hff);
    sw(8'h04, 8'h0a);
    fbw(18'h00006, 8'h5a);
    chk({mem_plane_en_q, mem_addr_q}, 32'h40001);
    sw(8'h04, 8'h02);
    fbw(18'h00005, 8'h5a);
    chk({mem_plane_en_q, mem_addr_q}, 32'ha0002);
    @(posedge clk_sys) fb_paged <= 1'b1;
    fbw(18'h00005, 8'h5a);
    chk({mem_plane_en_q, mem_addr_q}, 32'hf0005);
    @(posedge clk_sys) fb_paged <= 1'b0;
    sw(8'h02, 8'h03);
    fbw(18'h00005, 8'h5a);
    chk(mem_plane_en_q, 4'h2);
    sw(8'h04, 8'h04);
    fbw(18'h10000, 8'h5a);
    chk({fb_done_q, mem_wr_q}, 2'h2);
    sw(8'h04, 8'h06);
    fbw(18'h10000, 8'h5a);
    chk({fb_done_q, mem_wr_q}, 2'h3);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_font();
    t_write();
    t_steer();
    print_verdict();
  end
endmodule
`default_nettype wire
